// >>> hw/eth_dma_irq.sv
/*
  DMA interrupt status, receive interrupt watchdog, bus-error halt and
  transmit status write-back, behind a classic Wishbone register port.
  Assumes every event input except the deferring level is a one-cycle pulse from logic on clk.
*/
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
// Notes on behaviour
// RULE_01: A repeat event before service adds no further interrupt.
// RULE_02: Simultaneous events give one interrupt; new one only after clearing.
// RULE_03: Clearing receive-done keeps interrupt while enabled buffer-unavailable stays set.
// RULE_04: Non-zero watchdog starts on a frame whose descriptor asks no interrupt.
// RULE_05: Watchdog expiry sets receive-done and raises interrupt if enabled.
// RULE_06: A frame asking an interrupt cancels the watchdog and sets receive-done.
// RULE_07: Bus error halts the channel with error bits until soft reset.
// RULE_08: Normal four-word or enhanced eight-word descriptor, fixed once started.
// RULE_09: Descriptors bus-width aligned by software; data is little-endian.
// RULE_10: Each transmit frame closes at least one descriptor with status.
// RULE_11: Status word own bit is cleared when the frame is finished.
// RULE_12: Software hands over a frame's first descriptor last.
// RULE_13: Timestamp flag and value reported only on a last segment.
// RULE_14: IP header fault is flagged and checksum insertion bypassed.
// RULE_15: Error summary is the OR of the listed error bits.
// RULE_16: Jabber flagged only when not disabled; flush flagged separately.
// RULE_17: Payload checksum fault flagged when no checksum was inserted.
// RULE_18: Carrier loss and missing carrier each flagged.
// RULE_19: Abort after sixteen collisions, or the first one with retry off.
// RULE_20: Collision tally in bits six to three.
// RULE_21: Excessive deferral aborts beyond the selected bit-time limit.
// RULE_22: Underflow aborts, sets underflow and transmit interrupt status.
// RULE_23: Interrupt output only for events whose enable bit is set.
// RULE_24: Write one clears status; group summary clears with its enabled bits.
// RULE_25: Watchdog counts down on clk, reloading on each qualifying frame.
`timescale 1ns/1ps
`default_nettype none
module eth_dma_irq (
  input  wire logic                  clk,          // 20 MHz DMA clock
  input  wire logic                  reset_n,      // Async hard reset
  input  wire logic                  clkEn,        // Freezes state when low
  input  wire eth_dma_pkg::wb_req_t  wbIn,         // Wishbone request
  output logic                       wbAck,        // Wishbone ack
  output logic [31:0]                wbDatO,       // Wishbone read data
  input  wire logic                  rxFrameDone,  // Rx frame written to memory
  input  wire logic                  rxDescIrq,    // That descriptor asks interrupt
  input  wire logic                  rxBufUnavail, // Next rx descriptor host owned
  input  wire logic                  busErr,       // Slave error response
  input  wire logic [2:0]            busErrBits,   // Kind of failed access
  input  wire logic                  txStart,      // Tx frame begins
  input  wire logic                  txEnd,        // Tx frame ends
  input  wire logic                  txIrqReq,     // Interrupt on completion
  input  wire logic                  txLastSeg,    // Last segment descriptor
  input  wire logic                  txStampValid, // Timestamp captured
  input  wire logic [63:0]           txStamp,      // Captured timestamp
  input  wire eth_dma_pkg::tx_evt_t  txEvt,        // Tx error pulses
  input  wire logic                  collision,    // Collision pulse
  input  wire logic                  deferring,    // Deferral level
  input  wire logic                  bitTick,      // One per bit time
  output logic                       irqOut,       // Interrupt, high active
  output logic                       dmaHalted,    // Channel halted
  output logic                       descEnhanced, // Enhanced descriptors
  output logic [3:0]                 descWords,    // Words per descriptor
  output logic                       txAbort,      // Abort the frame
  output logic                       csumBypass,   // Skip checksum insertion
  output eth_dma_pkg::tx_done_t      txStatus      // Descriptor write-back
);
  import eth_dma_pkg::*;

  logic [31:0] status;
  logic [31:0] irqEn;
  logic [7:0]  wdtVal;
  logic [5:0]  cfg;
  logic [31:0] lastTxWord;
  logic [7:0]  wdtCnt;
  logic        wdtRun;

  // Byte lanes merge little-endian: lane 0 carries bits 7:0
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] wr,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wr[i*8 +: 8]; // RULE_09
      end
    end
    return res;
  endfunction

  // Bus decode; a write commits on the edge where the master sees ack
  wire        req     = wbIn.cyc & wbIn.stb;
  wire        wrEn    = req & wbIn.we & wbAck;
  wire        selSts  = wbIn.adr == OFS_STATUS;
  wire        selEn   = wbIn.adr == OFS_IRQ_EN;
  wire        selWdt  = wbIn.adr == OFS_RX_WDT;
  wire        selCfg  = wbIn.adr == OFS_CONFIG;
  wire        selTx   = wbIn.adr == OFS_TX_STAT;
  wire [31:0] wrData  = laneMerge(32'h0, wbIn.dat, wbIn.sel);
  wire [31:0] cfgWide = laneMerge({26'h0, cfg}, wbIn.dat, wbIn.sel);
  wire [31:0] wdtWide = laneMerge({24'h0, wdtVal}, wbIn.dat, wbIn.sel);
  wire        softRst = wrEn & selCfg & cfgWide[CFG_SRST];
  wire [31:0] clrBits = (wrEn & selSts) ? wrData & (NORMAL_MASK | ABNORMAL_MASK) : 32'h0; // RULE_24

  // Read mux; unmapped offsets read as zero and still get an ack
  wire [31:0] rdData = selSts ? status
                     : selEn  ? irqEn
                     : selWdt ? {24'h0, wdtVal}
                     : selCfg ? {26'h0, cfg}
                     : selTx  ? lastTxWord
                     : 32'h0;

  // Halted channel ignores traffic events; bus errors and a running watchdog's expiry still land
  wire live     = ~dmaHalted;
  wire rxDone   = live & rxFrameDone;
  wire wdtStart = rxDone & ~rxDescIrq & (wdtVal != 8'h0);  // RULE_04
  wire wdtFire  = wdtRun & (wdtCnt == 8'h1);               // RULE_05
  wire riSet    = (rxDone & rxDescIrq) | wdtFire;          // RULE_06
  wire txUnder  = txStatus.valid & txStatus.word[TX_UF];   // RULE_22
  wire txDoneEv = txUnder | (txStatus.valid & txIrqReq);

  // Set wins over a same-cycle clear, so no event is lost
  wire [31:0] setBits = ({31'h0, txDoneEv} << ST_TX_DONE)
                      | ({31'h0, txUnder} << ST_TX_UNDER)
                      | ({31'h0, riSet} << ST_RX_DONE)
                      | ({31'h0, live & rxBufUnavail} << ST_RX_NOBUF)
                      | ({31'h0, busErr} << ST_FATAL)      // RULE_07
                      | ({29'h0, busErr ? busErrBits : 3'h0} << ST_ERR_LSB);
  wire [31:0] srcBits = (status & ~clrBits) | setBits;     // RULE_01 RULE_02
  // Enables written on this edge count at once, so the line never lags a mask change
  wire [31:0] next_irqEn = softRst ? IRQ_EN_RST
                         : (wrEn & selEn) ? laneMerge(irqEn, wbIn.dat, wbIn.sel) : irqEn;
  wire        next_norm = |(srcBits & next_irqEn & NORMAL_MASK);   // RULE_24
  wire        next_abn  = |(srcBits & next_irqEn & ABNORMAL_MASK); // RULE_24
  wire [31:0] next_status = srcBits & (NORMAL_MASK | ABNORMAL_MASK)
                          | ({31'h0, next_norm} << ST_NORM_SUM)
                          | ({31'h0, next_abn} << ST_ABN_SUM);

  // Start bit locks the descriptor layout until a soft reset
  wire [5:0] next_cfg = {cfgWide[5] | cfg[CFG_START], cfgWide[4:1],
                         cfg[CFG_START] ? cfg[CFG_ENH] : cfgWide[CFG_ENH]}; // RULE_08

  // Wishbone answer: ack one cycle after the request, dropped the next
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wbAck <= 1'b0;
      wbDatO <= 32'h0;
    end else if (clkEn) begin
      wbAck <= req & ~wbAck;
      wbDatO <= (req & ~wbAck) ? rdData : 32'h0;
    end
  end

  // Software-owned registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqEn <= IRQ_EN_RST;
      wdtVal <= RX_WDT_RST;
      cfg <= CONFIG_RST;
    end else if (clkEn) begin
      if (softRst) begin
        irqEn <= IRQ_EN_RST;
        wdtVal <= RX_WDT_RST;
        cfg <= CONFIG_RST;
      end else begin
        irqEn <= next_irqEn;
        if (wrEn & selWdt) wdtVal <= wdtWide[7:0];
        if (wrEn & selCfg) cfg <= next_cfg;
      end
    end
  end

  // Status, summaries and the single registered interrupt line
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= STATUS_RST;
      irqOut <= 1'b0;
    end else if (clkEn) begin
      status <= softRst ? STATUS_RST : next_status;
      irqOut <= ~softRst & (next_norm | next_abn);         // RULE_23 RULE_03
    end
  end

  // Receive watchdog counts down; a qualifying frame landing on expiry restarts it, so none is lost
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wdtCnt <= 8'h0;
      wdtRun <= 1'b0;
    end else if (clkEn) begin
      if (softRst | (rxDone & rxDescIrq)) begin
        wdtRun <= 1'b0;                                     // RULE_06
        wdtCnt <= 8'h0;
      end else if (wdtStart) begin
        wdtRun <= 1'b1;                                     // RULE_25
        wdtCnt <= wdtVal;
      end else if (wdtFire) begin
        wdtRun <= 1'b0;
        wdtCnt <= 8'h0;
      end else if (wdtRun) begin
        wdtCnt <= wdtCnt - 8'h1;                            // RULE_25
      end
    end
  end

  // Halt is sticky; only a soft or hard reset releases it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dmaHalted <= 1'b0;
      descEnhanced <= 1'b0;
      descWords <= DESC_WORDS_NORM;
      lastTxWord <= 32'h0;
    end else if (clkEn) begin
      dmaHalted <= ~softRst & (dmaHalted | busErr);         // RULE_07
      descEnhanced <= (wrEn & selCfg & ~softRst) ? next_cfg[CFG_ENH] : (softRst ? 1'b0 : cfg[CFG_ENH]);
      descWords <= descEnhanced ? DESC_WORDS_ENH : DESC_WORDS_NORM; // RULE_08
      if (softRst) lastTxWord <= 32'h0;
      else if (txStatus.valid) lastTxWord <= txStatus.word;
    end
  end

  // Frame status composition; events are dropped once halted
  tx_status_builder txBuild (
    .clk        (clk),
    .reset_n    (reset_n),
    .clkEn      (clkEn),
    .clear      (softRst | dmaHalted),
    .txStart    (live & txStart),
    .txEnd      (live & txEnd),
    .txLastSeg  (txLastSeg),
    .stampValid (txStampValid),
    .stamp      (txStamp),
    .evt        (live ? txEvt : '0),
    .collision  (live & collision),
    .deferring  (deferring),
    .bitTick    (bitTick),
    .jabberOff  (cfg[CFG_JD]),
    .retryOff   (cfg[CFG_DR]),
    .deferChk   (cfg[CFG_DC]),
    .longDefer  (cfg[CFG_LONG]),
    .txStatus   (txStatus),
    .txAbort    (txAbort),
    .csumBypass (csumBypass)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_irq_follows_src: assert property ( // RULE_23
    (|(status & irqEn & (NORMAL_MASK | ABNORMAL_MASK))) |-> irqOut)
    else $error("enabled pending status without interrupt");
  a_irq_needs_enable: assert property ( // RULE_23
    irqOut |-> |(status & irqEn & (NORMAL_MASK | ABNORMAL_MASK)))
    else $error("interrupt raised without an enabled cause");
  a_nobuf_holds_irq: assert property ( // RULE_03
    (status[ST_RX_NOBUF] && irqEn[ST_RX_NOBUF]) |-> irqOut)
    else $error("interrupt dropped with buffer-unavailable pending");
  a_status_sticky: assert property ( // RULE_01
    (clkEn && status[ST_RX_DONE] && !clrBits[ST_RX_DONE] && !softRst) |=> status[ST_RX_DONE])
    else $error("receive-done lost without a clear");
  a_set_beats_clr: assert property ( // RULE_02
    (clkEn && riSet && !softRst) |=> status[ST_RX_DONE])
    else $error("receive-done event lost");
  a_wdt_start: assert property ( // RULE_04
    (clkEn && wdtStart && !softRst) |=> wdtRun && wdtCnt == $past(wdtVal))
    else $error("watchdog did not load on qualifying frame");
  a_wdt_expire: assert property ( // RULE_05
    (clkEn && wdtRun && wdtCnt == 8'h1 && !softRst) |=>
      status[ST_RX_DONE] && (wdtRun == $past(wdtStart)))
    else $error("watchdog expiry did not set receive-done");
  a_wdt_cancel: assert property ( // RULE_06
    (clkEn && rxDone && rxDescIrq && !softRst) |=> !wdtRun && status[ST_RX_DONE])
    else $error("interrupting frame did not cancel watchdog");
  a_bus_halt: assert property ( // RULE_07
    (clkEn && busErr && !softRst) |=> dmaHalted && status[ST_FATAL]
      ##1 (dmaHalted || $past(softRst)))
    else $error("bus error did not halt the channel");
  a_desc_locked: assert property ( // RULE_08
    ($past(cfg[CFG_START]) && !$past(softRst) && $past(clkEn)) |-> $stable(cfg[CFG_ENH]))
    else $error("descriptor layout changed while started");

  c_wdt_fire: cover property (wdtRun ##1 wdtFire ##1 irqOut);
  c_rx_clear_hold: cover property (status[ST_RX_NOBUF] && clrBits[ST_RX_DONE] ##1 irqOut);
  c_bus_halt: cover property (busErr ##1 dmaHalted);
  c_underflow: cover property (txUnder ##1 status[ST_TX_UNDER]);
endmodule
`default_nettype wire

// >>> hw/eth_dma_pkg.sv
/*
  Shared constants and carriers for the DMA interrupt and transmit-status block.
  Assumes one 20 MHz clock domain and a classic Wishbone register port.
*/
`default_nettype none
package eth_dma_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h04;
  localparam logic [7:0] OFS_RX_WDT  = 8'h08;
  localparam logic [7:0] OFS_CONFIG  = 8'h0c;
  localparam logic [7:0] OFS_TX_STAT = 8'h10;
  // Status register fields
  localparam int ST_TX_DONE   = 0;
  localparam int ST_TX_UNDER  = 5;
  localparam int ST_RX_DONE   = 6;
  localparam int ST_RX_NOBUF  = 7;
  localparam int ST_FATAL     = 13;
  localparam int ST_ABN_SUM   = 15;
  localparam int ST_NORM_SUM  = 16;
  localparam int ST_ERR_LSB   = 23;
  localparam logic [31:0] NORMAL_MASK   = 32'h00000041;
  localparam logic [31:0] ABNORMAL_MASK = 32'h038020a0;
  localparam logic [31:0] STATUS_RST    = 32'h00000000;
  localparam logic [31:0] IRQ_EN_RST    = 32'h00000000;
  localparam logic [7:0]  RX_WDT_RST    = 8'h00;
  // Configuration register fields
  localparam int CFG_ENH   = 0;
  localparam int CFG_JD    = 1;
  localparam int CFG_DR    = 2;
  localparam int CFG_DC    = 3;
  localparam int CFG_LONG  = 4;
  localparam int CFG_START = 5;
  localparam int CFG_SRST  = 31;
  localparam logic [5:0] CONFIG_RST = 6'h00;
  // Transmit status word fields
  localparam int TX_OWN  = 31;
  localparam int TX_TX_STAMP_CAPTURED = 17;
  localparam int TX_IHE  = 16;
  localparam int TX_ES   = 15;
  localparam int TX_JT   = 14;
  localparam int TX_FF   = 13;
  localparam int TX_PCE  = 12;
  localparam int TX_LC   = 11;
  localparam int TX_NC   = 10;
  localparam int TX_LATE = 9;
  localparam int TX_EC   = 8;
  localparam int TX_CC   = 3;
  localparam int TX_ED   = 2;
  localparam int TX_UF   = 1;
  localparam logic [31:0] ES_MASK = 32'h00017f06;
  // Limits and descriptor sizes
  localparam logic [4:0]  MAX_COLLISIONS  = 5'h10;
  localparam logic [17:0] DEFER_LIMIT     = 18'd24288;
  localparam logic [17:0] DEFER_LIMIT_LNG = 18'd155680;
  localparam logic [3:0]  DESC_WORDS_NORM = 4'h4;
  localparam logic [3:0]  DESC_WORDS_ENH  = 4'h8;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ipHdr;
    logic jabber;
    logic flushed;
    logic payload;
    logic carrierLost;
    logic noCarrier;
    logic lateColl;
    logic underflow;
  } tx_evt_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] word;
    logic [63:0] stamp;
  } tx_done_t;
endpackage
`default_nettype wire

// >>> hw/tx_status_builder.sv
/*
  Builds the per-frame transmit status word from MAC events.
  Assumes all event inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tx_status_builder (
  input  wire logic                  clk,         // DMA clock
  input  wire logic                  reset_n,     // Async reset
  input  wire logic                  clkEn,       // Freezes state when low
  input  wire logic                  clear,       // Soft reset or channel halt
  input  wire logic                  txStart,     // Frame begins
  input  wire logic                  txEnd,       // Frame ends
  input  wire logic                  txLastSeg,   // Last segment descriptor
  input  wire logic                  stampValid,  // Timestamp captured
  input  wire logic [63:0]           stamp,       // Captured timestamp
  input  wire eth_dma_pkg::tx_evt_t  evt,         // Error pulses
  input  wire logic                  collision,   // Collision pulse
  input  wire logic                  deferring,   // Deferral level
  input  wire logic                  bitTick,     // One per bit time
  input  wire logic                  jabberOff,   // Jabber check disabled
  input  wire logic                  retryOff,    // Abort on first collision
  input  wire logic                  deferChk,    // Deferral check on
  input  wire logic                  longDefer,   // Gigabit or jumbo
  output eth_dma_pkg::tx_done_t      txStatus,    // Composed status word
  output logic                       txAbort,     // Abort pulse
  output logic                       csumBypass   // No checksum insertion
);
  import eth_dma_pkg::*;

  logic [31:0] acc;
  logic [4:0]  collCnt;
  logic [17:0] deferCnt;

  // Event flags accumulate over the frame
  wire [31:0] evtBits = ({31'h0, evt.underflow} << TX_UF)
    | ({31'h0, evt.ipHdr} << TX_IHE)
    | ({31'h0, evt.jabber & ~jabberOff} << TX_JT)           // RULE_16
    | ({31'h0, evt.flushed} << TX_FF)                       // RULE_16
    | ({31'h0, evt.payload} << TX_PCE)                      // RULE_17
    | ({31'h0, evt.carrierLost} << TX_LC)                   // RULE_18
    | ({31'h0, evt.noCarrier} << TX_NC)                     // RULE_18
    | ({31'h0, evt.lateColl} << TX_LATE);
  wire [4:0]  collNext = collCnt + 5'h1;
  wire        excessColl = collision & (retryOff | collNext == MAX_COLLISIONS); // RULE_19
  wire [17:0] deferLim = longDefer ? DEFER_LIMIT_LNG : DEFER_LIMIT;
  wire        deferHit = deferChk & deferring & bitTick
                         & (deferCnt + 18'h1 > deferLim);    // RULE_21
  wire [31:0] next_acc = acc | evtBits | ({31'h0, excessColl} << TX_EC)
                         | ({31'h0, deferHit} << TX_ED);
  wire        frameDone = txEnd | excessColl | deferHit | evt.underflow; // RULE_22
  wire        tsOk = stampValid & txLastSeg;                // RULE_13
  // Own bit cleared, tally and summary folded in at close
  wire [31:0] base = (next_acc & ~(32'h1 << TX_OWN))        // RULE_11
                     | ({28'h0, collCnt[3:0]} << TX_CC)     // RULE_20
                     | ({31'h0, tsOk} << TX_TX_STAMP_CAPTURED);
  wire [31:0] closed = base | ({31'h0, |(base & ES_MASK)} << TX_ES); // RULE_15

  // Per-frame counters and flags; a new frame wipes the last one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc <= 32'h0;
      collCnt <= 5'h0;
      deferCnt <= 18'h0;
    end else if (clkEn) begin
      if (clear | txStart | frameDone) begin
        acc <= 32'h0;
        collCnt <= 5'h0;
        deferCnt <= 18'h0;
      end else begin
        acc <= next_acc;
        collCnt <= collision ? collNext : collCnt;
        deferCnt <= !deferring ? 18'h0 : (bitTick ? deferCnt + 18'h1 : deferCnt);
      end
    end
  end

  // One status write per frame; the word for descriptor status, stamp for the next two
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txStatus <= '0;
      txAbort <= 1'b0;
      csumBypass <= 1'b0;
    end else if (clkEn) begin
      txStatus.valid <= frameDone & ~clear & ~txStart;     // RULE_10
      if (frameDone) begin
        txStatus.word <= closed;
        txStatus.stamp <= tsOk ? stamp : 64'h0;            // RULE_13
      end
      txAbort <= (excessColl | deferHit | evt.underflow) & ~clear; // RULE_19
      csumBypass <= (clear | txStart) ? 1'b0 : next_acc[TX_IHE]; // RULE_14
    end
  end

  a_es_is_or: assert property (@(posedge clk) disable iff (!reset_n) // RULE_15
    txStatus.valid |-> txStatus.word[TX_ES] == |(txStatus.word & ES_MASK))
    else $error("error summary does not match its sources");
  a_own_cleared: assert property (@(posedge clk) disable iff (!reset_n) // RULE_11
    txStatus.valid |-> !txStatus.word[TX_OWN])
    else $error("closed descriptor still owned by DMA");
  a_ec_abort: assert property (@(posedge clk) disable iff (!reset_n) // RULE_19
    (clkEn && collision && retryOff && !clear && !txStart) |=> txAbort && txStatus.word[TX_EC])
    else $error("collision with retry off did not abort");
  c_excess_coll: cover property (@(posedge clk) disable iff (!reset_n)
    txStatus.valid && txStatus.word[TX_EC]);
endmodule
`default_nettype wire

// >>> tb/mac_tx_model.sv
/* Far-side MAC model: plays one transmit frame with a chosen number of collisions.
   Assumes go is a one-cycle pulse given while the model is idle. */
`timescale 1ns/1ps
`default_nettype none
module mac_tx_model (
  input  wire logic       clk,     // DMA clock
  input  wire logic       go,      // Start one frame
  input  wire logic [4:0] nColl,   // Collisions to play
  input  wire logic       abort,   // Block aborted the frame
  output logic            txStart, // Frame begins
  output logic            collide, // Collision pulse
  output logic            txEnd    // Frame ends
);
  logic [5:0] step;
  initial {step, txStart, collide, txEnd} = 9'h000;
  // One frame closes one descriptor; collisions spaced so each pulse stands alone
  always @(posedge clk) begin
    txStart <= go;
    step    <= go ? {nColl, 1'b1} + 6'h01 : (abort || step == 6'h00) ? 6'h00 : step - 6'h01;
    collide <= (step > 6'h02) && step[0];
    txEnd   <= (step == 6'h01) && !abort; // Late enough to see an abort
  end
endmodule
`default_nettype wire

// >>> tb/eth_dma_irq_tb.sv
/* Self-checking bench for the DMA interrupt and transmit-status block.
   Assumes the one-cycle Wishbone answer stated for the block. */
`timescale 1ns/1ps
`default_nettype none
module eth_dma_irq_tb;
  import eth_dma_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, clkEn = 1'b1, go = 1'b0;
  logic rxFrameDone = 1'b0, rxDescIrq = 1'b0, rxBufUnavail = 1'b0, busErr = 1'b0;
  logic txIrqReq = 1'b1, wbAck, irqOut, dmaHalted, descEnhanced, txAbort, csumBypass;
  logic txStart, txEnd, collide, txLastSeg = 1'b1;
  logic [2:0] busErrBits = 3'h5;
  logic [4:0] nColl = 5'h00;
  logic [3:0] descWords;
  logic [31:0] wbDatO, rd;
  wb_req_t wbIn = '0;
  tx_evt_t txEvt = '0;
  tx_done_t txStatus;
  int mismatches = 0, n_checks = 0;
  always #25 clk = ~clk;
  eth_dma_irq DUT (.clk, .reset_n, .clkEn, .wbIn, .wbAck, .wbDatO, .rxFrameDone, .rxDescIrq,
    .rxBufUnavail, .busErr, .busErrBits, .txStart, .txEnd, .txIrqReq, .txLastSeg,
    .txStampValid(1'b1), .txStamp(64'h0123456789abcdef), .txEvt, .collision(collide),
    .deferring(1'b0), .bitTick(1'b0), .irqOut, .dmaHalted, .descEnhanced, .descWords,
    .txAbort, .csumBypass, .txStatus);
  mac_tx_model far (.clk, .go, .nColl, .abort(txAbort), .txStart, .collide, .txEnd);
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Classic cycle: hold the request until ack is sampled, then release
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge clk) wbIn <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
    for (i = 0; i < 20 && wbAck !== 1'b1; i++) @(posedge clk);
    if (i == 20) begin
      mismatches++;
      conclude();
    end
    rd = wbDatO;
    wbIn <= '0;
  endtask
  task automatic rxPulse(input logic ask);
    @(posedge clk) rxFrameDone <= 1'b1;
    rxDescIrq <= ask;
    @(posedge clk) rxFrameDone <= 1'b0;
  endtask
  // Waits for the status write-back; a hang counts as a mismatch
  task automatic txFrame(input logic [4:0] n);
    int i;
    @(posedge clk) {go, nColl} <= {1'b1, n};
    @(posedge clk) go <= 1'b0;
    for (i = 0; i < 200 && txStatus.valid !== 1'b1; i++) @(posedge clk);
    if (i == 200) begin
      mismatches++;
      conclude();
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    wb(1'b0, OFS_STATUS, 32'h0); chk("status rst", rd, STATUS_RST);
    wb(1'b0, OFS_IRQ_EN, 32'h0); chk("irq_en rst", rd, IRQ_EN_RST);
    wb(1'b0, 8'h14, 32'h0);      chk("unmapped", rd, 32'h0);
    chk("desc words", descWords, {28'h0, DESC_WORDS_NORM});
    rxPulse(1'b1);
    rxPulse(1'b1);
    repeat (2) @(posedge clk);
    chk("irq masked", irqOut, 32'h0);
    wb(1'b0, OFS_STATUS, 32'h0); chk("rx done once", rd, 32'h00000040);
    wb(1'b1, OFS_IRQ_EN, 32'h0001a0e1);
    repeat (2) @(posedge clk);
    chk("irq on", irqOut, 32'h1);
    @(posedge clk) rxBufUnavail <= 1'b1;
    @(posedge clk) rxBufUnavail <= 1'b0;
    wb(1'b1, OFS_STATUS, 32'h00000040);
    repeat (2) @(posedge clk);
    chk("irq held", irqOut, 32'h1);
    wb(1'b0, OFS_STATUS, 32'h0); chk("nobuf left", rd, 32'h00008080);
    wb(1'b1, OFS_STATUS, 32'h00000080);
    repeat (2) @(posedge clk);
    chk("irq dropped", irqOut, 32'h0);
    wb(1'b1, OFS_RX_WDT, 32'h00000006);
    rxPulse(1'b0);
    repeat (6) @(posedge clk);
    chk("wdt running", irqOut, 32'h0);
    repeat (1) @(posedge clk);
    chk("wdt expired", irqOut, 32'h1);
    wb(1'b1, OFS_STATUS, 32'h00000040);
    rxPulse(1'b0);
    rxPulse(1'b1);
    wb(1'b1, OFS_STATUS, 32'h00000040);
    repeat (12) @(posedge clk);
    wb(1'b0, OFS_STATUS, 32'h0); chk("wdt cancelled", rd, 32'h0);
    txFrame(5'h03);
    chk("tx word", txStatus.word, 32'h00020018);
    chk("tx stamp", txStatus.stamp[31:0], 32'h89abcdef);
    chk("no abort", txAbort, 32'h0);
    wb(1'b0, OFS_TX_STAT, 32'h0); chk("tx stat reg", rd, 32'h00020018);
    wb(1'b0, OFS_STATUS, 32'h0); chk("tx done", rd, 32'h00010001);
    // Sixteen collisions with retry on, then one with retry off
    txFrame(5'h10);
    chk("ec abort", {txAbort, txStatus.word[31], txStatus.word[15], txStatus.word[8]}, 32'hb);
    wb(1'b1, OFS_CONFIG, 32'h00000004);
    txLastSeg <= 1'b0;
    txFrame(5'h01);
    chk("dr abort", {txAbort, txStatus.word[15], txStatus.word[8]}, 32'h7);
    chk("no stamp flag", txStatus.word[17], 32'h0);
    wb(1'b1, OFS_CONFIG, 32'h00000021);
    wb(1'b1, OFS_CONFIG, 32'h00000020);
    chk("desc locked", {descEnhanced, descWords}, 32'h18);
    wb(1'b1, OFS_STATUS, 32'hffffffff);
    @(posedge clk) busErr <= 1'b1;
    @(posedge clk) busErr <= 1'b0;
    rxPulse(1'b1);
    wb(1'b0, OFS_STATUS, 32'h0); chk("fatal bits", rd & 32'h038020c0, 32'h02802000);
    chk("halted", {dmaHalted, irqOut}, 32'h3);
    wb(1'b1, OFS_CONFIG, 32'h80000000);
    repeat (2) @(posedge clk);
    chk("soft reset", {dmaHalted, irqOut}, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
